// [pin_irq_consts.vh]
// Register offsets, field positions, reset values and bus constants
`ifndef PIN_IRQ_CONSTS_VH
`define PIN_IRQ_CONSTS_VH

// Register word indices; the bus byte address is four times the index
`define IDX_IRQ_FLAGS        10'h25f
`define IDX_IRQ_ENABLES      10'h25e
`define IDX_EDGE_POLARITY    10'h25d
`define IDX_INPUT_LEVELS     10'h269
`define IDX_DIG_IN_ENABLES   10'h26a
`define IDX_ANALOG_ACCESS    10'h26b
`define IDX_RUN_STATUS       10'h26c

// Register byte addresses
`define OFS_IRQ_FLAGS        {`IDX_IRQ_FLAGS, 2'b00}
`define OFS_IRQ_ENABLES      {`IDX_IRQ_ENABLES, 2'b00}
`define OFS_INPUT_LEVELS     {`IDX_INPUT_LEVELS, 2'b00}
`define OFS_DIG_IN_ENABLES   {`IDX_DIG_IN_ENABLES, 2'b00}
`define OFS_ANALOG_ACCESS    {`IDX_ANALOG_ACCESS, 2'b00}
`define OFS_EDGE_POLARITY    {`IDX_EDGE_POLARITY, 2'b00}
`define OFS_RUN_STATUS       {`IDX_RUN_STATUS, 2'b00}

// Field positions
`define BIT_OVERCURRENT      7
`define PIN_MSB              5
`define HV_PINS              4
`define AA_TEST_EN           7
`define AA_DIRECT            4
`define AA_CONNECT_EN        3
`define AA_SEL_MSB           1

// Reset values
`define RST_BYTE             8'h00

// Bus responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// [sync2.v]
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none

module sync2
#(
  parameter W = 1  // Number of bits
)
(
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;  // First stage, read only by second
  reg [W-1:0] out_q;   // Second stage

  // Two flip-flop chain, reset to low
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= {W{1'b0}};
      out_q  <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d;
      out_q  <= meta_q;
    end
  end

  assign q = out_q;

endmodule // sync2

`default_nettype wire

// [port_pin_irq_and_input_ctrl.v]
// Port pin interrupts, over-current interrupt and high-voltage input control
// How it works
// - Bit 7 enable gates over-current request
// - Bits 5-0 enable each pin's edge interrupt
// - Edges detected regardless of direction or function
// - Over-current report sets sticky flag bit 7
// - Active pin edge sets flag bits 5-0
// - Enabled set flag raises interrupt request
// - Writing one clears flag unless an event sets it in the same cycle
// - Digital enabled, non-analog pin reads synced level
// - Otherwise high-voltage pin reads as one, unless selected with its buffer on
// - Digital enable turns input buffer on
// - Run mode analog selection forces buffer off
// - Stop mode restores buffer if digitally enabled
// - Digital enable zero disables digital input
// - Polarity one rising, zero falling edge
// - Test enable keeps buffer on unless direct
// - Selector pin connects only when enabled
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pin_irq_consts.vh"

module port_pin_irq_and_input_ctrl
#(
  parameter GP_PINS = 6,  // General-purpose port pins with edge interrupts
  parameter HV_PINS = 4   // High-voltage input pins
)
(
  input  wire               clk,
  input  wire               nrst,
  // AXI4-Lite write address
  input  wire [11:0]        s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0]        s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Pins and analog side
  input  wire [GP_PINS-1:0] gp_port_pin,
  input  wire               protected_output_pin_overcurrent,
  input  wire [HV_PINS-1:0] high_voltage_input_pin,
  input  wire               stop_mode,
  output reg  [HV_PINS-1:0] hv_input_buffer_enable,
  output reg  [HV_PINS-1:0] adc_connect,
  output reg                adc_direct,
  output wire               irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Every software register is one byte in bits 7:0 of its word.
  // Flag and enable bit 6 have no source and always read zero.
  reg  [7:0]         flags_q;         // Sticky interrupt flags
  reg  [7:0]         enables_q;       // Interrupt enables
  reg  [7:0]         polarity_q;      // Edge polarity per pin
  reg  [7:0]         dig_en_q;        // High-voltage digital input enables
  reg  [7:0]         analog_q;        // Analog access control
  reg  [GP_PINS-1:0] gp_prev_q;       // Previous synced pin sample
  reg                oc_prev_q;       // Previous synced over-current level
  reg  [7:0]         flags_d;         // Next flag value
  reg  [7:0]         set_ev;          // Events this cycle
  reg  [7:0]         clr_mask;        // Write-one-to-clear mask

  wire [GP_PINS-1:0] gp_sync;         // Synced gp pins
  wire               oc_sync;         // Synced over-current report
  wire [HV_PINS-1:0] hv_sync;         // Synced hv pins
  wire               stop_sync;       // Synced stop mode
  wire [1:0]         sel;             // Analog selected pin
  wire               aa_en;           // Analog connection enabled
  wire               aa_test;         // Buffer test enable
  wire               aa_direct;       // Direct analog connection
  reg  [7:0]         hv_level;        // Read value of input levels

  // Write channel state
  reg                aw_have_q;       // Write address held
  reg                w_have_q;        // Write data held
  reg  [11:0]        awaddr_q;        // Held write address
  reg  [31:0]        wdata_q;         // Held write data
  reg  [3:0]         wstrb_q;         // Held strobes
  wire               wr_fire;         // Perform write this cycle

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin crosses two flops before any edge logic
  // Stop mode and the detector report share the chain, so a mode
  // change reaches the buffer logic two edges after the pin moves.
  // All stages reset low: a pin held high through reset shows one
  // rising edge once the chain fills, harmless under falling polarity.
  sync2 #(.W(GP_PINS + HV_PINS + 2)) u_sync
  (
    .clk  (clk),
    .nrst (nrst),
    .d    ({stop_mode, protected_output_pin_overcurrent, high_voltage_input_pin, gp_port_pin}),
    .q    ({stop_sync, oc_sync, hv_sync, gp_sync})
  );

  // Fields of the analog access register
  assign sel       = analog_q[`AA_SEL_MSB:0];
  assign aa_en     = analog_q[`AA_CONNECT_EN];
  assign aa_test   = analog_q[`AA_TEST_EN];
  assign aa_direct = analog_q[`AA_DIRECT];

  // ----------------------------------------------------------------
  // Edge detection and flags
  // ----------------------------------------------------------------
  // Event and clear vectors; set wins over clear
  // An edge is a difference between the synced sample and the one
  // taken an edge earlier, so a pin change lands in its flag three
  // edges after it appears. A clear write that meets a fresh event
  // in the same cycle leaves the flag set, so no edge is lost.
  integer i;
  always @*
  begin
    // Nothing set and nothing cleared unless found below
    set_ev   = 8'h00;
    clr_mask = 8'h00;
    // Pin edges seen on pin level whatever its direction or function
    for (i = 0; i < GP_PINS; i = i + 1)
    begin
      // Polarity one picks rising, zero falling
      if (polarity_q[i])
        set_ev[i] = gp_sync[i] & ~gp_prev_q[i];
      else
        set_ev[i] = ~gp_sync[i] & gp_prev_q[i];
    end
    // Over-current report rising sets flag
    set_ev[`BIT_OVERCURRENT] = oc_sync & ~oc_prev_q;
    // Only ones clear; zeros keep flags
    if (wr_fire && awaddr_q == `OFS_IRQ_FLAGS && wstrb_q[0])
      clr_mask = wdata_q[7:0];
    flags_d = (flags_q & ~clr_mask) | set_ev;
    // Bit 6 has no event behind it
    flags_d[6] = 1'b0;
  end

  // Flag and sample registers
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // No flags and idle samples after reset
      flags_q   <= `RST_BYTE;
      gp_prev_q <= {GP_PINS{1'b0}};
      oc_prev_q <= 1'b0;
    end
    else
    begin
      // Keep the current sample for the next comparison
      flags_q   <= flags_d;    // Sticky until cleared
      gp_prev_q <= gp_sync;
      oc_prev_q <= oc_sync;
    end
  end

  // Request while an enabled flag is set
  // Bit 6 is masked again so a stray enable bit can never matter
  assign irq = |(flags_q & enables_q & 8'hbf);

  // ----------------------------------------------------------------
  // High-voltage input path
  // ----------------------------------------------------------------
  // Buffer enables, read values and analog connection
  // Only the selected pin is touched by the analog function. In run
  // mode its buffer is off unless the test bit asks for it outside the
  // direct link; in stop mode it follows its digital enable again.
  // A pin whose buffer is off reads as one.
  integer j;
  always @*
  begin
    hv_level               = 8'h00;
    hv_input_buffer_enable = {HV_PINS{1'b0}};
    adc_connect            = {HV_PINS{1'b0}};
    adc_direct             = aa_en & aa_direct;
    // Defaults above, per-pin decisions below
    for (j = 0; j < HV_PINS; j = j + 1)
    begin
      // Buffer follows digital enable; zero disables
      hv_input_buffer_enable[j] = dig_en_q[j];
      // Analog selection overrides the plain enable
      if (aa_en && sel == j[1:0])
      begin
        // Selected pin connects only while enabled
        adc_connect[j] = 1'b1;
        if (stop_sync)
          hv_input_buffer_enable[j] = dig_en_q[j];
        else if (aa_test && !aa_direct)
          hv_input_buffer_enable[j] = 1'b1;
        else
          hv_input_buffer_enable[j] = 1'b0;
      end
      // Synced level when digital and not analog, or analog with buffer on, else one
      if (dig_en_q[j] && !(aa_en && sel == j[1:0]))
        hv_level[j] = hv_sync[j];
      else if (aa_en && sel == j[1:0] && hv_input_buffer_enable[j])
        hv_level[j] = hv_sync[j];
      else
        hv_level[j] = 1'b1;
    end
    // Bits above the pins read as zero
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Each half is accepted once and held until the pair is committed;
  // nothing new is taken while an answer waits, so one write at most
  // is under way. The commit edge also raises the answer.
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

  // Collect address and data in either order, then answer
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Idle channels and all registers cleared
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      enables_q    <= `RST_BYTE;
      polarity_q   <= `RST_BYTE;
      dig_en_q     <= `RST_BYTE;
      analog_q     <= `RST_BYTE;
    end
    else
    begin
      // Address accepted
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
      end
      // Data accepted
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      // Both halves present: commit the write and answer
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        // Only byte lane 0 carries register bits
        case (awaddr_q)
          `OFS_IRQ_FLAGS:
          begin
            // Handled in flag logic
          end
          `OFS_IRQ_ENABLES:
            if (wstrb_q[0]) enables_q <= wdata_q[7:0] & 8'hbf;
          `OFS_EDGE_POLARITY:
            if (wstrb_q[0]) polarity_q <= wdata_q[7:0] & 8'h3f;
          `OFS_DIG_IN_ENABLES:
            if (wstrb_q[0]) dig_en_q <= wdata_q[7:0] & 8'h0f;
          `OFS_ANALOG_ACCESS:
            if (wstrb_q[0]) analog_q <= wdata_q[7:0] & 8'hbb;
          `OFS_INPUT_LEVELS, `OFS_RUN_STATUS:
          begin
            // Read-only, write ignored
          end
          // Unmapped word: refuse
          default:
            s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      // Answer taken, channel free again
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // A new address is taken only while no answer waits, so reads are
  // answered one at a time, with the answer raised on the same edge that takes the address.
  assign s_axi_arready = !s_axi_rvalid;

  // Registered read data, one cycle after address
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // No answer pending
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    // Address taken: look up the register now
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      // Word address picks the register; low bits ignored
      case ({s_axi_araddr[11:2], 2'b00})
        `OFS_IRQ_FLAGS:      s_axi_rdata <= {24'h000000, flags_q};
        `OFS_IRQ_ENABLES:    s_axi_rdata <= {24'h000000, enables_q};
        `OFS_EDGE_POLARITY:  s_axi_rdata <= {24'h000000, polarity_q};
        `OFS_INPUT_LEVELS:   s_axi_rdata <= {24'h000000, hv_level};
        `OFS_DIG_IN_ENABLES: s_axi_rdata <= {24'h000000, dig_en_q};
        `OFS_ANALOG_ACCESS:  s_axi_rdata <= {24'h000000, analog_q};
        `OFS_RUN_STATUS:     s_axi_rdata <= {31'h00000000, stop_sync};
        default:
        begin
          // Unmapped word reads zero and is refused
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    // Answer taken
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // port_pin_irq_and_input_ctrl

`default_nettype wire

// [pin_world.sv]
// Far-side model: external port pins and the over-current detector
`timescale 1ns/100ps
`default_nettype none
module pin_world
(
  input  wire logic [5:0] gp_want,                          // Levels put on the port pins
  input  wire logic       oc_want,                          // Over-current condition present
  input  wire logic [3:0] hv_want,                          // High-voltage pin levels
  output wire logic [5:0] gp_port_pin,                      // Port pins as the block sees them
  output wire logic       protected_output_pin_overcurrent, // Detector report, high on over-current
  output wire logic [3:0] high_voltage_input_pin            // High-voltage pins as the block sees them
);
  // Pins are driven levels; the detector reports the condition while it lasts
  assign gp_port_pin = gp_want;
  assign protected_output_pin_overcurrent = oc_want;
  assign high_voltage_input_pin = hv_want;
endmodule // pin_world
`default_nettype wire

// [pin_irq_monitor.sv]
// Assertion checker on the pin interrupt and input control ports
`timescale 1ns/100ps
`default_nettype none
module pin_irq_monitor
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [5:0] gp_port_pin,
  input wire logic       protected_output_pin_overcurrent,
  input wire logic       stop_mode,
  input wire logic [3:0] hv_input_buffer_enable,
  input wire logic [3:0] adc_connect,
  input wire logic       adc_direct,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] quiet_q;  // Edges since the last write or input movement
  // Restart the count on a bus write or a change of the port pins, over-current report or stop mode
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      quiet_q <= 3'h0;
    else if (s_axi_awvalid || s_axi_bvalid || !$stable({gp_port_pin, protected_output_pin_overcurrent, stop_mode}))
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h7)
      quiet_q <= quiet_q + 3'h1;
  // Run mode held long enough to pass the synchroniser
  sequence run_settled;
    !stop_mode [*3];
  endsequence
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped before taken");
  a_resp_follows: assert property ($rose(s_axi_bvalid) |-> quiet_q < 3'h4)
    else $error("write answer without a write");
  a_select_onehot: assert property ($onehot0(adc_connect))
    else $error("more than one pin on the converter");
  a_direct_pin: assert property (adc_direct |-> |adc_connect)
    else $error("direct link with no pin connected");
  a_adc_steady: assert property (quiet_q >= 3'h5 |-> $stable(adc_connect))
    else $error("converter link moved with no write");
  a_irq_steady: assert property (quiet_q >= 3'h5 |-> $stable(irq))
    else $error("irq moved with no cause");
  a_buf_steady: assert property (quiet_q >= 3'h5 |-> $stable(hv_input_buffer_enable))
    else $error("buffer enables moved with no cause");
  a_direct_buf_off: assert property (run_settled ##0 adc_direct |-> !(|(hv_input_buffer_enable & adc_connect)))
    else $error("direct analog pin has its buffer on");
endmodule // pin_irq_monitor
bind port_pin_irq_and_input_ctrl pin_irq_monitor mon (.clk, .nrst, .s_axi_awvalid, .s_axi_bvalid, .s_axi_bready,
  .gp_port_pin, .protected_output_pin_overcurrent, .stop_mode, .hv_input_buffer_enable, .adc_connect,
  .adc_direct, .irq);
`default_nettype wire

// [port_pin_irq_and_input_ctrl_tb.sv]
// Self-checking bench for the pin interrupt and input control block
`timescale 1ns/100ps
`default_nettype none
`include "pin_irq_consts.vh"
module port_pin_irq_and_input_ctrl_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        clk = 1'b0, nrst = 1'b0, stop_mode = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  gp_want = 6'h00, gp_port_pin;
  logic        oc_want = 1'b0, protected_output_pin_overcurrent, adc_direct, irq;
  logic [3:0]  hv_want = 4'h0, high_voltage_input_pin, hv_input_buffer_enable, adc_connect;
  wire logic [7:0] outs = {adc_connect, hv_input_buffer_enable};  // Converter connections and buffer enables together; adc_direct checked apart
  int          n_errors = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  pin_world pins (.gp_want, .oc_want, .hv_want, .gp_port_pin, .protected_output_pin_overcurrent,
    .high_voltage_input_pin);
  port_pin_irq_and_input_ctrl dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gp_port_pin,
    .protected_output_pin_overcurrent, .high_voltage_input_pin, .stop_mode, .hv_input_buffer_enable,
    .adc_connect, .adc_direct, .irq);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bail;
    n_errors++;
    $display("ERROR bus answer expected 1 seen 0");
    close_out();
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  // Bus write: both items offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) bail();
    check("bresp", {6'h00, er}, {6'h00, s_axi_bresp});
  endtask
  // Bus read, masked compare of the low byte
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e, input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) bail();
    check("rresp", {6'h00, er}, {6'h00, s_axi_rresp});
    check("rdata", e, s_axi_rdata[7:0] & m);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check("irq", 8'h00, {7'h00, irq});
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h00);
    rd(`OFS_IRQ_ENABLES, 8'hff, 8'h00);
    check("outs", 8'h00, outs);
  endtask
  task automatic t_edges;
    wr(`OFS_EDGE_POLARITY, 8'h3f);
    rd(`OFS_EDGE_POLARITY, 8'hff, 8'h3f);
    wr(`OFS_IRQ_ENABLES, 8'h3f);
    gp_want <= 6'h2a;
    settle();
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h2a);
    check("irq", 8'h01, {7'h00, irq});
    gp_want <= 6'h00;
    settle();
    wr(`OFS_IRQ_FLAGS, 8'h00);
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h2a);
    wr(`OFS_IRQ_FLAGS, 8'h0a);
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h20);
    wr(`OFS_EDGE_POLARITY, 8'h00);
    gp_want <= 6'h3f;
    settle();
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h20);
    gp_want <= 6'h00;
    settle();
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h3f);
    wr(`OFS_IRQ_ENABLES, 8'h00);
    check("irq", 8'h00, {7'h00, irq});
    wr(`OFS_IRQ_FLAGS, 8'h3f);
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h00);
  endtask
  task automatic t_oc;
    oc_want <= 1'b1;
    settle();
    oc_want <= 1'b0;
    rd(`OFS_IRQ_FLAGS, 8'hff, 8'h80);
    check("irq", 8'h00, {7'h00, irq});
    wr(`OFS_IRQ_ENABLES, 8'h80);
    check("irq", 8'h01, {7'h00, irq});
    wr(`OFS_IRQ_FLAGS, 8'h80);
    check("irq", 8'h00, {7'h00, irq});
  endtask
  task automatic t_hv;
    hv_want <= 4'ha;
    settle();
    rd(`OFS_INPUT_LEVELS, 8'h0f, 8'h0f);
    wr(`OFS_DIG_IN_ENABLES, 8'h0f);
    check("outs", 8'h0f, outs);
    rd(`OFS_INPUT_LEVELS, 8'h0f, 8'h0a);
    wr(`OFS_ANALOG_ACCESS, 8'h08);
    check("outs", 8'h1e, outs);
    rd(`OFS_INPUT_LEVELS, 8'h0f, 8'h0b);
    wr(`OFS_ANALOG_ACCESS, 8'h88);
    check("outs", 8'h1f, outs);
    rd(`OFS_INPUT_LEVELS, 8'h0f, 8'h0a);
    wr(`OFS_ANALOG_ACCESS, 8'h98);
    check("outs", 8'h1e, outs);
    check("direct", 8'h01, {7'h00, adc_direct});
    rd(`OFS_ANALOG_ACCESS, 8'hff, 8'h98);
    stop_mode <= 1'b1;
    settle();
    check("outs", 8'h1f, outs);
    rd(`OFS_RUN_STATUS, 8'hff, 8'h01);
    wr(`OFS_DIG_IN_ENABLES, 8'h0e);
    check("outs", 8'h1e, outs);
    stop_mode <= 1'b0;
    wr(`OFS_ANALOG_ACCESS, 8'h03);
    check("outs", 8'h0e, outs);
    wr(`OFS_DIG_IN_ENABLES, 8'h00);
    check("outs", 8'h00, outs);
    rd(`OFS_RUN_STATUS, 8'hff, 8'h00);
    rd(`OFS_DIG_IN_ENABLES, 8'hff, 8'h00);
  endtask
  task automatic t_unmapped;
    wr(12'h100, 8'h5a, `RESP_SLVERR);
    rd(12'h100, 8'hff, 8'h00, `RESP_SLVERR);
    wr(`OFS_INPUT_LEVELS, 8'h55);
    rd(`OFS_INPUT_LEVELS, 8'h0f, 8'h0f);
    wr(`OFS_IRQ_ENABLES, 8'hff);
    rd(`OFS_IRQ_ENABLES, 8'hff, 8'hbf);
  endtask
  // Reset for 16 edges, then every scenario in turn
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_edges();
    t_oc();
    t_hv();
    t_unmapped();
    close_out();
  end
endmodule // port_pin_irq_and_input_ctrl_tb
`default_nettype wire
